// [rtcpc_pkg.sv]
package rtcpc_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ = 20_000;
	localparam int DEBOUNCE_MS = 250;
	localparam int RST_MS = 250;
	localparam int REC_MS = 125;
	localparam int STOP_MS = 100;
	localparam int IFTO_MS = 25;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
	localparam int RST_CYC = RST_MS * CLK_KHZ;
	localparam int REC_CYC = REC_MS * CLK_KHZ;
	localparam int STOP_CYC = STOP_MS * CLK_KHZ;
	localparam int IFTO_CYC = IFTO_MS * CLK_KHZ;
	localparam int TMR_W = 23;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] MASK_OFS = 8'h08;
	localparam logic [7:0] STATE_OFS = 8'h0C;

	localparam int CTRL_W = 8;
	localparam int C_CLKOUT_EN = 0;
	localparam int C_CLKOUT_BAT_EN = 1;
	localparam int C_IRQ_SEL = 2;
	localparam int C_RATE_LO = 3;
	localparam int C_RATE_HI = 4;
	localparam int C_OSC_DIS = 5;
	localparam int C_ALM1_EN = 6;
	localparam int C_ALM2_EN = 7;
	localparam logic [7:0] CTRL_RST = 8'h1D;

	localparam int ST_W = 5;
	localparam int S_STOP = 0;
	localparam int S_ALARM = 1;
	localparam int S_BUTTON = 2;
	localparam int S_PFAIL = 3;
	localparam int S_IFTO = 4;
	localparam logic [4:0] STAT_RST = 5'h00;
	localparam logic [4:0] MASK_RST = 5'h00;

	// ----------------------------------------------------------------
	// square wave: half period in oscillator rising edges, per rate code
	// ----------------------------------------------------------------
	localparam int SQ_CNT_W = 16;
	localparam logic [3:0][15:0] SQ_HALF_DEF = {16'h0002, 16'h0004, 16'h0010, 16'h4000};

	typedef enum logic [2:0] {
		RS_IDLE,
		RS_PFAIL,
		RS_HOLD,
		RS_DEBOUNCE,
		RS_WAIT_RISE
	} rtcpc_rst_state_t;
endpackage

// [rtcpc_timer.sv]
`timescale 1ns/1ps
module rtcpc_timer #(
	parameter int W = 23
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic run,
	input wire logic [W-1:0] limit,
	output logic done
);
	logic [W-1:0] cnt_q;

	assign done = (cnt_q == limit);

	// saturates at the limit so done stays up until cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (clk_en) begin
			if (clear) begin
				cnt_q <= '0;
			end else if (run && !done) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule

// [rtcpc_top.sv]
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module rtcpc_top #(
	parameter int unsigned DEBOUNCE_CYC = rtcpc_pkg::DEBOUNCE_CYC,
	parameter int unsigned RST_CYC = rtcpc_pkg::RST_CYC,
	parameter int unsigned REC_CYC = rtcpc_pkg::REC_CYC,
	parameter int unsigned STOP_CYC = rtcpc_pkg::STOP_CYC,
	parameter int unsigned IFTO_CYC = rtcpc_pkg::IFTO_CYC,
	parameter logic [3:0][15:0] SQ_HALF = rtcpc_pkg::SQ_HALF_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rtcpc_pkg::AW-1:0] paddr,
	input wire logic [rtcpc_pkg::DW-1:0] pwdata,
	output logic [rtcpc_pkg::DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_clk_pin,
	input wire logic below_power_fail_threshold,
	input wire logic [1:0] alarm_match,
	input wire logic bus_busy,
	input wire logic bus_activity,
	output logic serial_abort,
	output logic reference_clock_out,
	output logic irq_or_square_pin_o,
	output logic irq_or_square_pin_oe_n,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_n,
	output logic irq
);
	import rtcpc_pkg::*;

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	localparam logic [TMR_W-1:0] DEBOUNCE_LIM = TMR_W'(DEBOUNCE_CYC - 1);
	localparam logic [TMR_W-1:0] RST_LIM = TMR_W'(RST_CYC - 1);
	localparam logic [TMR_W-1:0] REC_LIM = TMR_W'(REC_CYC - 1);
	localparam logic [TMR_W-1:0] STOP_LIM = TMR_W'(STOP_CYC - 1);
	localparam logic [TMR_W-1:0] IFTO_LIM = TMR_W'(IFTO_CYC - 1);

	if (DEBOUNCE_CYC < 2 || DEBOUNCE_CYC > 2**TMR_W || RST_CYC < 2 || RST_CYC > 2**TMR_W ||
			REC_CYC < 2 || REC_CYC > 2**TMR_W || STOP_CYC < 2 || STOP_CYC > 2**TMR_W ||
			IFTO_CYC < 2 || IFTO_CYC > 2**TMR_W) begin : g_bad_cyc
		$error("timer counts must lie between 2 and the timer range");
	end
	for (genvar r = 0; r < 4; r++) begin : g_chk_half
		if (SQ_HALF[r] == 16'h0000) begin : g_bad_half
			$error("square wave half period must be nonzero");
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers: osc, power fail, reset pin
	// ----------------------------------------------------------------
	logic [2:0] pin_raw;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] sync3_q;

	assign pin_raw = {rst_pin_i, below_power_fail_threshold, osc_clk_pin};

	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
				sync3_q[i] <= 1'b0;
			end else if (clk_en) begin
				sync1_q[i] <= pin_raw[i];
				sync2_q[i] <= sync1_q[i];
				sync3_q[i] <= sync2_q[i];
			end
		end
	end

	logic osc_s;
	logic osc_rise;
	logic pf_s;
	logic rst_in_s;
	logic rst_fall;
	logic rst_rise;

	assign osc_s = sync2_q[0];
	assign osc_rise = sync2_q[0] && !sync3_q[0];
	assign pf_s = sync2_q[1];
	assign rst_in_s = sync2_q[2];
	assign rst_fall = !sync2_q[2] && sync3_q[2];
	assign rst_rise = sync2_q[2] && !sync3_q[2];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_q;
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] status_d;
	logic [ST_W-1:0] mask_q;
	logic [ST_W-1:0] events;
	logic [DW-1:0] prdata_q;
	logic [DW-1:0] prdata_d;
	logic mapped;
	logic wr_acc;
	logic rd_stat;
	rtcpc_rst_state_t state_q;
	rtcpc_rst_state_t state_d;
	logic osc_stopped_det;

	assign mapped = (paddr == CTRL_OFS) || (paddr == STAT_OFS) ||
		(paddr == MASK_OFS) || (paddr == STATE_OFS);
	assign wr_acc = clk_en && psel && penable && pwrite && mapped;
	assign rd_stat = clk_en && psel && penable && !pwrite && (paddr == STAT_OFS);
	// zero wait states; a frozen block holds the bus off
	assign pready = clk_en;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
			mask_q <= MASK_RST;
		end else if (wr_acc) begin
			if (paddr == CTRL_OFS) begin
				ctrl_q <= pwdata[CTRL_W-1:0];
			end
			if (paddr == MASK_OFS) begin
				mask_q <= pwdata[ST_W-1:0];
			end
		end
	end

	always_comb begin
		case (paddr)
			CTRL_OFS: prdata_d = DW'(ctrl_q);
			STAT_OFS: prdata_d = DW'(status_q);
			MASK_OFS: prdata_d = DW'(mask_q);
			STATE_OFS: prdata_d = DW'({!rst_pin_oe_n, pf_s, rst_in_s, osc_stopped_det,
				state_q});
			default: prdata_d = '0;
		endcase
	end

	// read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (clk_en && psel && !penable) begin
			prdata_q <= prdata_d;
		end
	end

	// only bits that were returned are cleared; a new event always wins
	always_comb begin
		status_d = status_q;
		if (rd_stat) begin
			status_d = status_q & ~prdata_q[ST_W-1:0];
		end
		status_d = status_d | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= STAT_RST;
		end else if (clk_en) begin
			status_q <= status_d;
		end
	end

	assign irq = |(status_q & mask_q);

	// ----------------------------------------------------------------
	// reference clock and shared alarm / square-wave pin
	// ----------------------------------------------------------------
	logic ref_q;
	logic sq_q;
	logic [SQ_CNT_W-1:0] sq_cnt_q;
	logic [SQ_CNT_W-1:0] sq_half;
	logic alarm_hit;
	logic alarm_hit_q;

	assign sq_half = SQ_HALF[{ctrl_q[C_RATE_HI], ctrl_q[C_RATE_LO]}];
	assign alarm_hit = (alarm_match[0] && ctrl_q[C_ALM1_EN]) ||
		(alarm_match[1] && ctrl_q[C_ALM2_EN]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q <= 1'b0;
		end else if (clk_en) begin
			ref_q <= osc_s && ctrl_q[C_CLKOUT_EN] && ctrl_q[C_CLKOUT_BAT_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sq_cnt_q <= '0;
			sq_q <= 1'b1;
		end else if (clk_en && osc_rise) begin
			if (sq_cnt_q >= sq_half - 1'b1) begin
				sq_cnt_q <= '0;
				sq_q <= !sq_q;
			end else begin
				sq_cnt_q <= sq_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_hit_q <= 1'b0;
		end else if (clk_en) begin
			alarm_hit_q <= alarm_hit;
		end
	end

	assign reference_clock_out = ref_q;
	assign irq_or_square_pin_o = 1'b0;
	// open drain: pulling low means enabling the driver
	assign irq_or_square_pin_oe_n = ctrl_q[C_IRQ_SEL] ? !alarm_hit : sq_q;

	// ----------------------------------------------------------------
	// oscillator stop and serial timeout
	// ----------------------------------------------------------------
	logic osc_stop_q;
	logic ifto_done;
	logic ifto_q;

	rtcpc_timer #(.W(TMR_W)) u_osc_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.clear(osc_rise),
		.run(1'b1),
		.limit(STOP_LIM),
		.done(osc_stopped_det)
	);

	// activity or an idle bus restarts the count
	rtcpc_timer #(.W(TMR_W)) u_ifto_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.clear(bus_activity || !bus_busy),
		.run(bus_busy),
		.limit(IFTO_LIM),
		.done(ifto_done)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_stop_q <= 1'b0;
			ifto_q <= 1'b0;
		end else if (clk_en) begin
			osc_stop_q <= osc_stopped_det;
			ifto_q <= ifto_done;
		end
	end

	assign serial_abort = clk_en && ifto_done && !ifto_q;

	// ----------------------------------------------------------------
	// reset pin sequencer
	// ----------------------------------------------------------------
	logic tmr_done;
	logic hold_rec_q;
	logic osc_off;
	logic [TMR_W-1:0] tmr_lim;

	assign osc_off = ctrl_q[C_OSC_DIS] || osc_stopped_det;

	always_comb begin
		state_d = state_q;
		case (state_q)
			RS_IDLE: begin
				if (rst_fall) begin
					state_d = RS_DEBOUNCE;
				end
			end
			RS_DEBOUNCE: begin
				// pin is held low here; the drive is dropped in RS_WAIT_RISE so the button release can be seen
				if (tmr_done) begin
					state_d = RS_WAIT_RISE;
				end
			end
			RS_WAIT_RISE: begin
				if (rst_rise) begin
					state_d = RS_HOLD;
				end
			end
			RS_HOLD: begin
				if (tmr_done) begin
					state_d = RS_IDLE;
				end
			end
			RS_PFAIL: begin
				if (!pf_s) begin
					state_d = osc_off ? RS_IDLE : RS_HOLD;
				end
			end
			default: state_d = RS_IDLE;
		endcase
		if (pf_s) begin
			state_d = RS_PFAIL;
		end
	end

	always_comb begin
		case (state_q)
			RS_DEBOUNCE: tmr_lim = DEBOUNCE_LIM;
			RS_HOLD: tmr_lim = hold_rec_q ? REC_LIM : RST_LIM;
			default: tmr_lim = '1;
		endcase
	end

	rtcpc_timer #(.W(TMR_W)) u_rst_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.clear(state_d != state_q),
		.run(1'b1),
		.limit(tmr_lim),
		.done(tmr_done)
	);

	// the pin drives nothing back into the block: no register is reset by it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= RS_IDLE;
			hold_rec_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			if (state_d == RS_HOLD && state_q != RS_HOLD) begin
				hold_rec_q <= (state_q == RS_PFAIL);
			end
		end
	end

	assign rst_pin_o = 1'b0;
	assign rst_pin_oe_n = !(state_q == RS_PFAIL || state_q == RS_HOLD ||
		state_q == RS_DEBOUNCE);

	assign events[S_STOP] = osc_stopped_det && !osc_stop_q;
	assign events[S_ALARM] = ctrl_q[C_IRQ_SEL] && alarm_hit && !alarm_hit_q;
	assign events[S_BUTTON] = clk_en && state_q == RS_IDLE && state_d == RS_DEBOUNCE;
	assign events[S_PFAIL] = clk_en && pf_s && state_q != RS_PFAIL;
	assign events[S_IFTO] = serial_abort;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	clkout_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && !(ctrl_q[C_CLKOUT_EN] && ctrl_q[C_CLKOUT_BAT_EN])) |=> !reference_clock_out)
		else $error("reference clock not held low while disabled");

	square_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_q[C_IRQ_SEL] && clk_en && osc_rise && sq_cnt_q == sq_half - 1'b1)
		|=> irq_or_square_pin_oe_n != $past(irq_or_square_pin_oe_n))
		else $error("square wave did not toggle at its half period");

	alarm_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q[C_IRQ_SEL] && alarm_hit) |-> !irq_or_square_pin_oe_n)
		else $error("alarm match did not pull the shared pin low");

	powerup_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> ctrl_q[C_IRQ_SEL] && !ctrl_q[C_ALM1_EN] && !ctrl_q[C_ALM2_EN])
		else $error("wrong shared pin mode after reset");

	pfail_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && pf_s) |=> !rst_pin_oe_n)
		else $error("reset pin released during power fail");

	hold_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && state_q == RS_HOLD && tmr_done && !pf_s) |=> rst_pin_oe_n)
		else $error("reset pin not released after hold");

	debounce_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && state_q == RS_IDLE && rst_fall && !pf_s) |=> !rst_pin_oe_n [*2])
		else $error("pushbutton edge not answered by a low drive");

	bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && state_q == RS_PFAIL && !pf_s && osc_off) |=> rst_pin_oe_n)
		else $error("recovery hold-off not bypassed with oscillator off");

	stop_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && osc_stopped_det && !osc_stop_q) |=> status_q[S_STOP])
		else $error("oscillator stop flag not set");

	ifto_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && bus_busy && !bus_activity && ifto_done && !ifto_q) |-> serial_abort)
		else $error("serial timeout did not abandon the transfer");

	rec_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && state_q == RS_PFAIL && !pf_s && !osc_off) |=> state_q == RS_HOLD && hold_rec_q)
		else $error("recovery hold not entered after supply returns");
endmodule

// [rtcpc_pins_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host board: pull-ups on both open-drain wires, pushbutton to ground
// ----------------------------------------------------------------
module rtcpc_pins_model (
	input wire logic press,
	input wire logic rst_pin_o,
	input wire logic rst_pin_oe_n,
	input wire logic irq_or_square_pin_o,
	input wire logic irq_or_square_pin_oe_n,
	output logic rst_pin_i,
	output logic irq_line
);
	// the button shorts the wire while held, whatever the device does
	assign rst_pin_i = ((!rst_pin_oe_n && !rst_pin_o) || press) ? 1'b0 : 1'b1;
	assign irq_line = (!irq_or_square_pin_oe_n && !irq_or_square_pin_o) ? 1'b0 : 1'b1;
endmodule

// [rtc_pin_output_and_reset_control_bench.sv]
`timescale 1ns/1ps
module rtc_pin_output_and_reset_control_bench;
	import rtcpc_pkg::*;
	// ----------------------------------------------------------------
	// shortened intervals
	// ----------------------------------------------------------------
	localparam int PB = 20;
	localparam int RS = 24;
	localparam int RC = 16;
	localparam int OS = 40;
	localparam int TO = 12;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, last_err;
	logic osc_clk_pin = 1'b0;
	logic osc_run = 1'b1;
	logic pf = 1'b0;
	logic [1:0] alarm_match = 2'b00;
	logic bus_busy = 1'b0;
	logic bus_activity = 1'b0;
	logic press = 1'b0;
	logic clk_en = 1'b1;
	logic serial_abort, reference_clock_out, sq_o, sq_oe_n, irq_line;
	logic rst_pin_i, rst_pin_o, rst_pin_oe_n, irq;
	logic [31:0] r;
	int n, aborts, bad_count, n_tests;
	int half [4] = '{16384, 16, 4, 2};

	rtcpc_top #(.DEBOUNCE_CYC(PB), .RST_CYC(RS), .REC_CYC(RC), .STOP_CYC(OS),
		.IFTO_CYC(TO)) rtcpc_top_i (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_clk_pin(osc_clk_pin), .below_power_fail_threshold(pf),
		.alarm_match(alarm_match), .bus_busy(bus_busy), .bus_activity(bus_activity),
		.serial_abort(serial_abort), .reference_clock_out(reference_clock_out),
		.irq_or_square_pin_o(sq_o), .irq_or_square_pin_oe_n(sq_oe_n), .rst_pin_i(rst_pin_i),
		.rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n), .irq(irq));

	rtcpc_pins_model rtcpc_pins_model_i (
		.press(press), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n),
		.irq_or_square_pin_o(sq_o), .irq_or_square_pin_oe_n(sq_oe_n),
		.rst_pin_i(rst_pin_i), .irq_line(irq_line));

	always #25 pclk = ~pclk;
	// oscillator far faster than real so that divider ratios show in short runs
	always begin
		repeat (8) @(posedge pclk);
		if (osc_run) osc_clk_pin <= ~osc_clk_pin;
	end
	// the pulse is combinational, so look mid-cycle where it has settled
	always @(negedge pclk) begin
		if (serial_abort === 1'b1) aborts++;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			bad_count++;
			end_sim();
		end
	endtask

	task automatic wait_rst(input logic lvl);
		int k;
		k = 0;
		while (rst_pin_oe_n !== lvl && k < 6) begin
			@(negedge pclk);
			k++;
		end
		check("reset pin drive", 32'(rst_pin_oe_n), 32'(lvl));
		if (rst_pin_oe_n !== lvl) end_sim();
	endtask

	task automatic low_len();
		n = 0;
		while (rst_pin_oe_n === 1'b0 && n < 1000) begin
			@(negedge pclk);
			n++;
		end
	endtask

	task automatic toggles(input logic sel, input int cyc);
		logic prev;
		n = 0;
		prev = sel ? irq_line : reference_clock_out;
		repeat (cyc) begin
			@(negedge pclk);
			if ((sel ? irq_line : reference_clock_out) !== prev) n++;
			prev = sel ? irq_line : reference_clock_out;
		end
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CTRL_OFS, 32'h0);
		check("ctrl reset", r, 32'h1D);
		apb(1'b0, MASK_OFS, 32'h0);
		check("mask reset", r, 32'h0);
		check("shared pin idle", 32'(irq_line), 32'h1);
		apb(1'b1, 8'h10, 32'hFF);
		check("unmapped error", 32'(last_err), 32'h1);
		$display("test reset values done");

		// either enable low keeps the clock output parked low
		foreach (half[q]) begin
			if (q < 2) begin
				apb(1'b1, CTRL_OFS, 32'h1C | 32'(1 << q));
				toggles(1'b0, 80);
				check("clkout gated", 32'(n) | 32'(reference_clock_out), 32'h0);
			end
		end
		apb(1'b1, CTRL_OFS, 32'h1F);
		toggles(1'b0, 80);
		check("clkout runs", 32'(n >= 8), 32'h1);
		$display("test clock output done");

		apb(1'b1, CTRL_OFS, 32'h5F);
		apb(1'b0, STAT_OFS, 32'h0);
		@(posedge pclk);
		alarm_match <= 2'b01;
		@(negedge pclk);
		check("alarm pulls pin", 32'(irq_line), 32'h0);
		check("masked irq", 32'(irq), 32'h0);
		apb(1'b1, MASK_OFS, 32'h2);
		@(negedge pclk);
		check("irq raised", 32'(irq), 32'h1);
		apb(1'b0, STAT_OFS, 32'h0);
		check("alarm status", r & 32'h2, 32'h2);
		@(negedge pclk);
		check("irq cleared", 32'(irq), 32'h0);
		@(posedge pclk);
		alarm_match <= 2'b10;
		@(negedge pclk);
		check("disabled alarm", 32'(irq_line), 32'h1);
		alarm_match <= 2'b00;
		$display("test alarm interrupt done");

		for (int q = 2; q < 4; q++) begin
			apb(1'b1, CTRL_OFS, 32'h03 | 32'(q << 3));
			toggles(1'b1, 320);
			check("square rate", 32'(n >= 320 / (16 * half[q]) - 1 &&
				n <= 320 / (16 * half[q]) + 1), 32'h1);
		end
		$display("test square wave done");

		apb(1'b1, CTRL_OFS, 32'h1F);
		pf <= 1'b1;
		wait_rst(1'b0);
		apb(1'b0, CTRL_OFS, 32'h0);
		check("ctrl during reset", r, 32'h1F);
		check("pfail holds pin", 32'(rst_pin_oe_n), 32'h0);
		pf <= 1'b0;
		low_len();
		check("recovery length", 32'(n >= RC && n <= RC + 5), 32'h1);
		apb(1'b1, CTRL_OFS, 32'h3F);
		pf <= 1'b1;
		wait_rst(1'b0);
		repeat (4) @(posedge pclk);
		pf <= 1'b0;
		low_len();
		check("hold bypass", 32'(n <= 4), 32'h1);
		apb(1'b1, CTRL_OFS, 32'h1F);
		$display("test power fail done");

		press <= 1'b1;
		wait_rst(1'b0);
		low_len();
		check("debounce length", 32'(n >= PB - 2 && n <= PB + 2), 32'h1);
		repeat (10) @(negedge pclk);
		check("waits for release", 32'(rst_pin_oe_n), 32'h1);
		@(posedge pclk);
		press <= 1'b0;
		wait_rst(1'b0);
		low_len();
		check("release hold", 32'(n >= RS - 2 && n <= RS + 2), 32'h1);
		apb(1'b0, STAT_OFS, 32'h0);
		check("button status", r & 32'h4, 32'h4);
		$display("test pushbutton done");

		osc_run <= 1'b0;
		repeat (15) @(negedge pclk);
		apb(1'b0, STAT_OFS, 32'h0);
		check("stop flag early", r & 32'h1, 32'h0);
		repeat (40) @(negedge pclk);
		apb(1'b0, STAT_OFS, 32'h0);
		check("stop flag", r & 32'h1, 32'h1);
		osc_run <= 1'b1;
		$display("test oscillator stop done");

		// a low clock enable must freeze the running clock output
		repeat (40) @(posedge pclk);
		clk_en <= 1'b0;
		toggles(1'b0, 80);
		check("frozen clkout", 32'(n), 32'h0);
		@(posedge pclk);
		clk_en <= 1'b1;
		toggles(1'b0, 80);
		check("clkout resumes", 32'(n >= 8), 32'h1);
		$display("test clock enable done");

		@(posedge pclk);
		bus_busy <= 1'b1;
		aborts = 0;
		repeat (5) begin
			repeat (7) @(posedge pclk);
			bus_activity <= 1'b1;
			@(posedge pclk);
			bus_activity <= 1'b0;
		end
		repeat (TO - 3) @(posedge pclk);
		check("no early abort", 32'(aborts), 32'h0);
		repeat (9) @(posedge pclk);
		check("abort once", 32'(aborts), 32'h1);
		bus_busy <= 1'b0;
		$display("test interface timeout done");
		end_sim();
	end
endmodule
